// file: dxi_exec.sv
// Divide and increment execution datapath with its bus sequencer
`timescale 1ns/1ps
`default_nettype none
`include "dxi_consts.svh"
module dxi_exec (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [15:0] pc_in,
  input wire logic [15:0] index_y,
  input wire logic load_en,
  input wire logic [7:0] load_upper,
  input wire logic [7:0] load_lower,
  input wire logic [15:0] load_index,
  input wire logic [15:0] load_sp,
  input wire logic [7:0] load_flags,
  input wire logic [7:0] bus_rdata,
  output logic [15:0] bus_addr,
  output logic bus_rw,
  output logic [7:0] bus_wdata,
  output logic bus_active,
  output logic ready,
  output logic done,
  output logic illegal,
  output logic [7:0] upper_accumulator,
  output logic [7:0] lower_accumulator,
  output logic [15:0] first_index_reg,
  output logic [15:0] stack_pointer,
  output logic [7:0] flag_register
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic dxi_pkg::dxi_class_t dec_op(input logic pre, input logic [7:0] op);
    dxi_pkg::dxi_class_t c;
    c = dxi_pkg::cl_illegal;
    if (pre) begin
      if (op == `DXI_OP_INC_IDX) c = dxi_pkg::cl_inc_iy;
    end else begin
      case (op)
        `DXI_OP_FRACTIONAL_DIVIDE_OP: c = dxi_pkg::cl_frac_div;
        `DXI_OP_INTEGER_DIVIDE_OP: c = dxi_pkg::cl_int_div;
        `DXI_OP_INCREMENT_UPPER_ACC_OP: c = dxi_pkg::cl_inc_upper;
        `DXI_OP_INCREMENT_LOWER_ACC_OP: c = dxi_pkg::cl_inc_lower;
        `DXI_OP_INC_EXT: c = dxi_pkg::cl_inc_ext;
        `DXI_OP_INC_IDX: c = dxi_pkg::cl_inc_ix;
        `DXI_OP_PREFIX: c = dxi_pkg::cl_prefix;
        `DXI_OP_INS: c = dxi_pkg::cl_sp_inc;
        `DXI_OP_INX: c = dxi_pkg::cl_index_inc;
        default: c = dxi_pkg::cl_illegal;
      endcase
    end
    return c;
  endfunction

  // Number of the last bus cycle of each class; a prefix never ends
  function automatic logic [5:0] last_cyc(input dxi_pkg::dxi_class_t c);
    logic [5:0] n;
    n = `DXI_CYC_0;
    case (c)
      dxi_pkg::cl_frac_div, dxi_pkg::cl_int_div: n = `DXI_CYC_DIV;
      dxi_pkg::cl_inc_upper, dxi_pkg::cl_inc_lower: n = `DXI_CYC_2;
      dxi_pkg::cl_sp_inc, dxi_pkg::cl_index_inc: n = `DXI_CYC_3;
      dxi_pkg::cl_inc_ext, dxi_pkg::cl_inc_ix: n = `DXI_CYC_MEM;
      dxi_pkg::cl_inc_iy: n = `DXI_CYC_MEM_Y;
      default: n = `DXI_CYC_0;
    endcase
    return n;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dxi_pkg::dxi_state_t st_q;
  dxi_pkg::dxi_class_t cls_q;
  logic [5:0] cyc_q;
  logic [15:0] pc_q, addr_q, ea_q, ix_q, sp_q, num_q, den_q;
  logic [7:0] wdata_q, hi_q, lo_q, mem_q, acc_hi_q, acc_lo_q, flags_q;
  logic rw_q, active_q, ready_q, done_q, ill_q, dz_q, ovf_q;
  logic [15:0] addr_d, ix_d, sp_d;
  logic [7:0] acc_hi_d, acc_lo_d, flags_d;

  // ----------------------------------------------------------------
  // Combinational decode and selection
  // ----------------------------------------------------------------
  wire run_w = (st_q == dxi_pkg::st_run);
  wire dxi_pkg::dxi_class_t cls_now_w =
    (cyc_q == `DXI_CYC_1) ? dec_op(1'b0, bus_rdata) :
    (cls_q == dxi_pkg::cl_prefix && cyc_q == `DXI_CYC_2) ? dec_op(1'b1, bus_rdata) : cls_q;
  wire [5:0] last_w = last_cyc(cls_now_w);
  wire [5:0] rd_cyc_w = last_w - `DXI_CYC_2;
  wire [5:0] nxt_w = cyc_q + `DXI_CYC_1;
  wire fin_w = run_w && (cls_now_w == dxi_pkg::cl_illegal || cyc_q == last_w);
  wire is_div_w = (cls_now_w == dxi_pkg::cl_frac_div) || (cls_now_w == dxi_pkg::cl_int_div);
  wire is_mem_w = (cls_now_w == dxi_pkg::cl_inc_ext) || (cls_now_w == dxi_pkg::cl_inc_ix) ||
                  (cls_now_w == dxi_pkg::cl_inc_iy);
  wire div_start_w = run_w && (cyc_q == `DXI_CYC_1) && is_div_w;
  wire [15:0] pair_w = {acc_hi_q, acc_lo_q};
  wire [15:0] base_w = (cls_now_w == dxi_pkg::cl_inc_iy) ? index_y : ix_q;
  // Extended address low byte arrives in the same cycle the address is formed
  wire [15:0] ea_w = (cls_now_w == dxi_pkg::cl_inc_ext) ? {hi_q, bus_rdata} :
                     base_w + {`DXI_ZERO8, lo_q};
  wire [7:0] inc_in_w = (cls_now_w == dxi_pkg::cl_inc_upper) ? acc_hi_q :
                        (cls_now_w == dxi_pkg::cl_inc_lower) ? acc_lo_q : mem_q;
  wire rw_nxt_w = !(is_mem_w && nxt_w == last_w);

  logic [7:0] inc_res_w;
  logic inc_n_w, inc_z_w, inc_v_w;
  logic [15:0] quot_w, rem_w;

  dxi_inc8 #(.W(8)) u_inc (
    .operand(inc_in_w),
    .result(inc_res_w),
    .neg(inc_n_w),
    .zero(inc_z_w),
    .ovf(inc_v_w)
  );

  dxi_divider #(.W(16)) u_div (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .start(div_start_w),
    .frac(cls_now_w == dxi_pkg::cl_frac_div),
    .num(pair_w),
    .den(ix_q),
    .quot(quot_w),
    .rem(rem_w),
    .busy()
  );

  // Forced quotient on fractional overflow or a zero divisor
  wire force_w = dz_q || (cls_now_w == dxi_pkg::cl_frac_div && ovf_q);
  wire [15:0] qres_w = force_w ? `DXI_ALL_ONES : quot_w;
  wire [15:0] ix_inc_w = ix_q + `DXI_ONE16;

  // ----------------------------------------------------------------
  // Next bus cycle
  // ----------------------------------------------------------------
  always_comb begin
    addr_d = `DXI_IDLE_ADDR;
    if (nxt_w == `DXI_CYC_2) begin
      addr_d = pc_q + `DXI_ONE16;
    end else begin
      case (cls_now_w)
        dxi_pkg::cl_sp_inc: addr_d = sp_q;
        dxi_pkg::cl_inc_ext, dxi_pkg::cl_inc_ix, dxi_pkg::cl_inc_iy: begin
          if (nxt_w == rd_cyc_w) begin
            addr_d = ea_w;
          end else if (nxt_w == last_w) begin
            addr_d = ea_q;
          end else if (nxt_w == `DXI_CYC_3 && cls_now_w != dxi_pkg::cl_inc_ix) begin
            addr_d = pc_q + `DXI_TWO16;
          end
        end
        default: addr_d = `DXI_IDLE_ADDR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Results at the end of the last cycle
  // ----------------------------------------------------------------
  always_comb begin
    acc_hi_d = acc_hi_q;
    acc_lo_d = acc_lo_q;
    ix_d = ix_q;
    sp_d = sp_q;
    flags_d = flags_q;
    if (fin_w) begin
      case (cls_now_w)
        dxi_pkg::cl_frac_div, dxi_pkg::cl_int_div: begin
          ix_d = qres_w;
          {acc_hi_d, acc_lo_d} = rem_w;
          flags_d[`DXI_FLG_Z] = (qres_w == `DXI_ZERO16);
          flags_d[`DXI_FLG_V] = (cls_now_w == dxi_pkg::cl_frac_div) && ovf_q;
          flags_d[`DXI_FLG_C] = dz_q;
        end
        dxi_pkg::cl_inc_upper, dxi_pkg::cl_inc_lower, dxi_pkg::cl_inc_ext,
        dxi_pkg::cl_inc_ix, dxi_pkg::cl_inc_iy: begin
          if (cls_now_w == dxi_pkg::cl_inc_upper) acc_hi_d = inc_res_w;
          if (cls_now_w == dxi_pkg::cl_inc_lower) acc_lo_d = inc_res_w;
          // Carry kept so loops over multi-byte sums stay intact
          flags_d[`DXI_FLG_N] = inc_n_w;
          flags_d[`DXI_FLG_Z] = inc_z_w;
          flags_d[`DXI_FLG_V] = inc_v_w;
        end
        dxi_pkg::cl_sp_inc: sp_d = sp_q + `DXI_ONE16;
        dxi_pkg::cl_index_inc: begin
          ix_d = ix_inc_w;
          flags_d[`DXI_FLG_Z] = (ix_inc_w == `DXI_ZERO16);
        end
        default: flags_d = flags_q;
      endcase
    end else if (!run_w && load_en) begin
      acc_hi_d = load_upper;
      acc_lo_d = load_lower;
      ix_d = load_index;
      sp_d = load_sp;
      flags_d = load_flags;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= dxi_pkg::st_idle;
      cls_q <= dxi_pkg::cl_illegal;
      cyc_q <= `DXI_CYC_0;
      pc_q <= `DXI_ZERO16;
      addr_q <= `DXI_IDLE_ADDR;
      rw_q <= 1'b1;
      active_q <= 1'b0;
      ready_q <= 1'b1;
      done_q <= 1'b0;
      ill_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      ill_q <= 1'b0;
      case (st_q)
        dxi_pkg::st_idle: begin
          if (start) begin
            st_q <= dxi_pkg::st_run;
            cyc_q <= `DXI_CYC_1;
            pc_q <= pc_in;
            addr_q <= pc_in;
            rw_q <= 1'b1;
            active_q <= 1'b1;
            ready_q <= 1'b0;
          end
        end
        dxi_pkg::st_run: begin
          cls_q <= cls_now_w;
          if (fin_w) begin
            st_q <= dxi_pkg::st_idle;
            addr_q <= `DXI_IDLE_ADDR;
            rw_q <= 1'b1;
            active_q <= 1'b0;
            ready_q <= 1'b1;
            done_q <= 1'b1;
            ill_q <= (cls_now_w == dxi_pkg::cl_illegal);
          end else begin
            cyc_q <= nxt_w;
            addr_q <= addr_d;
            rw_q <= rw_nxt_w;
          end
        end
        default: st_q <= dxi_pkg::st_idle;
      endcase
    end
  end

  // Operand bytes and divide conditions
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hi_q <= `DXI_ZERO8;
      lo_q <= `DXI_ZERO8;
      mem_q <= `DXI_ZERO8;
      ea_q <= `DXI_ZERO16;
      wdata_q <= `DXI_ZERO8;
      num_q <= `DXI_ZERO16;
      den_q <= `DXI_ZERO16;
      dz_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      if (run_w && cyc_q == `DXI_CYC_2) hi_q <= bus_rdata;
      if (run_w && (cyc_q == `DXI_CYC_2 ||
          (cyc_q == `DXI_CYC_3 && cls_now_w == dxi_pkg::cl_inc_iy))) lo_q <= bus_rdata;
      if (run_w && is_mem_w && nxt_w == rd_cyc_w) ea_q <= ea_w;
      if (run_w && is_mem_w && cyc_q == rd_cyc_w) mem_q <= bus_rdata;
      if (run_w && is_mem_w && nxt_w == last_w) wdata_q <= inc_res_w;
      if (div_start_w) begin
        num_q <= pair_w;
        den_q <= ix_q;
        dz_q <= (ix_q == `DXI_ZERO16);
        ovf_q <= (ix_q <= pair_w);
      end
    end
  end

  // Architectural registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acc_hi_q <= `DXI_ZERO8;
      acc_lo_q <= `DXI_ZERO8;
      ix_q <= `DXI_ZERO16;
      sp_q <= `DXI_ZERO16;
      flags_q <= `DXI_FLAGS_RST;
    end else begin
      acc_hi_q <= acc_hi_d;
      acc_lo_q <= acc_lo_d;
      ix_q <= ix_d;
      sp_q <= sp_d;
      flags_q <= flags_d;
    end
  end

  assign bus_addr = addr_q;
  assign bus_rw = rw_q;
  assign bus_wdata = wdata_q;
  assign bus_active = active_q;
  assign ready = ready_q;
  assign done = done_q;
  assign illegal = ill_q;
  assign upper_accumulator = acc_hi_q;
  assign lower_accumulator = acc_lo_q;
  assign first_index_reg = ix_q;
  assign stack_pointer = sp_q;
  assign flag_register = flags_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  wire div_done_w = done_q && (cls_q == dxi_pkg::cl_frac_div || cls_q == dxi_pkg::cl_int_div);
  wire mem_cls_w = (cls_q == dxi_pkg::cl_inc_ext) || (cls_q == dxi_pkg::cl_inc_ix) ||
                   (cls_q == dxi_pkg::cl_inc_iy);

  sequence s_write_then_done;
    (!rw_q && cyc_q == last_cyc(cls_q)) ##1 (done_q && rw_q);
  endsequence

  AST_FRACTIONAL_DIVIDE_OP_QUOT: assert property (@(posedge sys_clk) disable iff (!resetn)
    done_q && cls_q == dxi_pkg::cl_frac_div && !ovf_q |->
    ({16'h0000, ix_q} * {16'h0000, den_q}) + {16'h0000, pair_w} == {num_q, 16'h0000})
    else $error("fractional quotient or remainder wrong");
  AST_DIV_FORCED: assert property (@(posedge sys_clk) disable iff (!resetn)
    div_done_w && (dz_q || (cls_q == dxi_pkg::cl_frac_div && ovf_q)) |-> ix_q == 16'hFFFF)
    else $error("quotient not forced to all ones");
  AST_DIV_FLAGS: assert property (@(posedge sys_clk) disable iff (!resetn)
    div_done_w |-> flags_q[`DXI_FLG_C] == dz_q && flags_q[`DXI_FLG_Z] == (ix_q == 16'h0000) &&
    flags_q[`DXI_FLG_V] == (cls_q == dxi_pkg::cl_frac_div && den_q <= num_q))
    else $error("divide flags wrong");
  AST_INTEGER_DIVIDE_OP_QUOT: assert property (@(posedge sys_clk) disable iff (!resetn)
    done_q && cls_q == dxi_pkg::cl_int_div && !dz_q |->
    ({16'h0000, ix_q} * {16'h0000, den_q}) + {16'h0000, pair_w} == {16'h0000, num_q})
    else $error("integer quotient or remainder wrong");
  AST_DIV_IDLE_READS: assert property (@(posedge sys_clk) disable iff (!resetn)
    active_q && (cls_q == dxi_pkg::cl_frac_div || cls_q == dxi_pkg::cl_int_div) &&
    cyc_q >= `DXI_CYC_3 |-> addr_q == 16'hFFFF && rw_q)
    else $error("divide idle cycle not an idle read");
  AST_DIV_LENGTH: assert property (@(posedge sys_clk) disable iff (!resetn)
    div_done_w |-> cyc_q == `DXI_CYC_DIV && $past(active_q))
    else $error("divide did not take 41 cycles");
  AST_INC_CARRY: assert property (@(posedge sys_clk) disable iff (!resetn)
    active_q && (mem_cls_w || cls_q == dxi_pkg::cl_inc_upper || cls_q == dxi_pkg::cl_inc_lower)
    |=> $stable(flags_q[`DXI_FLG_C]))
    else $error("increment changed carry");
  AST_INC_WRITE: assert property (@(posedge sys_clk) disable iff (!resetn)
    active_q && !rw_q |-> mem_cls_w && addr_q == ea_q ##0 s_write_then_done)
    else $error("write cycle outside final increment cycle");
  AST_SP_INC: assert property (@(posedge sys_clk) disable iff (!resetn)
    done_q && cls_q == dxi_pkg::cl_sp_inc |->
    sp_q == $past(sp_q) + 16'h0001 && flags_q == $past(flags_q))
    else $error("stack increment wrong");
  AST_INX_FLAGS: assert property (@(posedge sys_clk) disable iff (!resetn)
    done_q && cls_q == dxi_pkg::cl_index_inc |-> ix_q == $past(ix_q) + 16'h0001 &&
    flags_q[`DXI_FLG_Z] == (ix_q == 16'h0000) && flags_q[3:0] == {$past(flags_q[3]),
    flags_q[2], $past(flags_q[1]), $past(flags_q[0])})
    else $error("index increment flags wrong");

endmodule
`default_nettype wire

// file: dxi_consts.svh
// Constants for the divide and increment execution unit
// What this block does
// - Fractional divide: paired accumulator over index, quotient to index, remainder to pair.
// - Fractional overflow or zero divisor forces quotient to all ones.
// - Fractional divide sets zero flag when the quotient is zero.
// - Fractional divide sets overflow when divisor is not above the dividend.
// - Fractional divide sets carry when the divisor was zero.
// - Fractional divide opcode 03, 41 cycles, cycles 3 to 41 idle reads.
// - Integer divide: quotient to index, remainder to paired accumulator.
// - Integer divide quotient is a whole number.
// - Integer divide by zero loads all ones into the quotient.
// - Integer divide sets zero on zero quotient and always clears overflow.
// - Integer divide sets carry when the divisor was zero.
// - Integer divide opcode 02, 41 cycles, 39 idle reads at the idle address.
// - Byte increment adds one to an accumulator or memory byte, wrapping.
// - Byte increment leaves the carry flag alone.
// - Byte increment: negative copies bit 7, zero set on zero result.
// - Byte increment sets overflow exactly when the operand was 7F.
// - Increment opcodes, cycle counts and, for memory increments, final write cycle with strobe low.
// - Stack pointer increment, no flags, opcode 31, third cycle reads at stack.
// - Index increment, opcode 08, 3 cycles, third an idle read.
// - Index increment updates only zero, set on a zero 16-bit result.
`ifndef DXI_CONSTS_SVH
`define DXI_CONSTS_SVH

`define DXI_OP_FRACTIONAL_DIVIDE_OP 8'h03
`define DXI_OP_INTEGER_DIVIDE_OP 8'h02
`define DXI_OP_INCREMENT_UPPER_ACC_OP 8'h4C
`define DXI_OP_INCREMENT_LOWER_ACC_OP 8'h5C
`define DXI_OP_INC_EXT 8'h7C
`define DXI_OP_INC_IDX 8'h6C
`define DXI_OP_PREFIX 8'h18
`define DXI_OP_INS 8'h31
`define DXI_OP_INX 8'h08

`define DXI_IDLE_ADDR 16'hFFFF
`define DXI_ALL_ONES 16'hFFFF
`define DXI_ZERO16 16'h0000
`define DXI_ONE16 16'h0001
`define DXI_TWO16 16'h0002
`define DXI_ZERO8 8'h00
`define DXI_ZERO32 32'h0000_0000

`define DXI_CYC_0 6'h00
`define DXI_CYC_1 6'h01
`define DXI_CYC_2 6'h02
`define DXI_CYC_3 6'h03
`define DXI_CYC_MEM 6'h06
`define DXI_CYC_MEM_Y 6'h07
`define DXI_CYC_DIV 6'h29

`define DXI_FLG_C 0
`define DXI_FLG_V 1
`define DXI_FLG_Z 2
`define DXI_FLG_N 3
`define DXI_FLAGS_RST 8'hD0

`endif

// file: dxi_pkg.sv
// Types shared by the divide and increment execution unit
`default_nettype none
package dxi_pkg;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_run = 2'b10
  } dxi_state_t;

  typedef enum logic [10:0] {
    cl_frac_div = 11'h001,
    cl_int_div = 11'h002,
    cl_inc_upper = 11'h004,
    cl_inc_lower = 11'h008,
    cl_sp_inc = 11'h010,
    cl_index_inc = 11'h020,
    cl_inc_ext = 11'h040,
    cl_inc_ix = 11'h080,
    cl_inc_iy = 11'h100,
    cl_prefix = 11'h200,
    cl_illegal = 11'h400
  } dxi_class_t;

endpackage
`default_nettype wire

// file: dxi_inc8.sv
// Byte incrementer with its flag results
`timescale 1ns/1ps
`default_nettype none
module dxi_inc8 #(
  parameter int W = 8
) (
  input wire logic [W-1:0] operand,
  output logic [W-1:0] result,
  output logic neg,
  output logic zero,
  output logic ovf
);

  // Wraps modulo 2**W
  assign result = operand + {{(W-1){1'b0}}, 1'b1};
  // Sign and zero of the result
  assign neg = result[W-1];
  assign zero = (result == '0);
  // Only the largest positive value overflows
  assign ovf = (operand == {1'b0, {(W-1){1'b1}}});

endmodule
`default_nettype wire

// file: dxi_divider.sv
// Iterative unsigned restoring divider, integer or fraction
`timescale 1ns/1ps
`default_nettype none
module dxi_divider #(
  parameter int W = 16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic frac,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  output logic [W-1:0] quot,
  output logic [W-1:0] rem,
  output logic busy
);

  localparam int CW = $clog2(W + 1);

  logic [W:0] rem_q;
  logic [W-1:0] sh_q;
  logic [W-1:0] den_q;
  logic [CW-1:0] cnt_q;

  wire [W:0] trial_w = {rem_q[W-1:0], sh_q[W-1]};
  wire [W:0] diff_w = trial_w - {1'b0, den_q};
  wire fits_w = ~diff_w[W];

  // A fraction is the numerator times 2**W: preload it as the partial remainder
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rem_q <= '0;
      sh_q <= '0;
      den_q <= '0;
      cnt_q <= '0;
    end else if (start) begin
      rem_q <= frac ? {1'b0, num} : '0;
      sh_q <= frac ? '0 : num;
      den_q <= den;
      cnt_q <= CW'(W);
    end else if (cnt_q != '0) begin
      rem_q <= fits_w ? diff_w : trial_w;
      sh_q <= {sh_q[W-2:0], fits_w};
      cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  assign quot = sh_q;
  assign rem = rem_q[W-1:0];
  assign busy = (cnt_q != '0);

  AST_DIV_STEPS: assert property (@(posedge sys_clk) disable iff (!resetn)
    start |=> busy ##15 busy ##1 !busy)
    else $error("divider step count wrong");

endmodule
`default_nettype wire

// file: dxi_mem_model.sv
// Behavioural memory on the processor bus for the divide and increment unit
`timescale 1ns/1ps
`default_nettype none
module dxi_mem_model (
  input wire logic sys_clk,
  input wire logic [15:0] bus_addr,
  input wire logic bus_rw,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_active,
  output logic [7:0] bus_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q;
  initial begin
    last_q = 8'h00;
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  end
  task automatic poke(input logic [15:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask
  // Outside a read cycle show the inverse of the last byte, never a stale copy
  assign bus_rdata = (bus_active && bus_rw) ? mem[bus_addr] : ~last_q;
  always @(posedge sys_clk) begin
    if (bus_active && bus_rw) last_q <= mem[bus_addr];
    if (bus_active && !bus_rw) mem[bus_addr] <= bus_wdata;
  end
endmodule
`default_nettype wire

// file: dxi_exec_test.sv
// Self-checking testbench for the divide and increment unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module dxi_exec_test;
  logic sys_clk, resetn, start, load_en, bus_rw, bus_active, ready, done, illegal;
  logic [15:0] pc_in, index_y, load_index, load_sp, bus_addr, first_index_reg, stack_pointer;
  logic [7:0] load_upper, load_lower, load_flags, bus_rdata, bus_wdata;
  logic [7:0] upper_accumulator, lower_accumulator, flag_register;
  logic [15:0] alog [0:63];
  logic rlog [0:63];
  logic [7:0] wlog [0:63];
  int errors = 0;
  int check_count = 0;
  dxi_exec DUT (.sys_clk(sys_clk), .resetn(resetn), .start(start), .pc_in(pc_in),
    .index_y(index_y), .load_en(load_en), .load_upper(load_upper), .load_lower(load_lower),
    .load_index(load_index), .load_sp(load_sp), .load_flags(load_flags),
    .bus_rdata(bus_rdata), .bus_addr(bus_addr), .bus_rw(bus_rw), .bus_wdata(bus_wdata),
    .bus_active(bus_active), .ready(ready), .done(done), .illegal(illegal),
    .upper_accumulator(upper_accumulator), .lower_accumulator(lower_accumulator),
    .first_index_reg(first_index_reg), .stack_pointer(stack_pointer),
    .flag_register(flag_register));
  dxi_mem_model MEM (.sys_clk(sys_clk), .bus_addr(bus_addr), .bus_rw(bus_rw),
    .bus_wdata(bus_wdata), .bus_active(bus_active), .bus_rdata(bus_rdata));
  // ----------------------------------------
  // Bus-level helpers
  // ----------------------------------------
  task automatic ld(input logic [15:0] pair, ix, sp, input logic [7:0] fl);
    load_upper = pair[15:8];
    load_lower = pair[7:0];
    load_index = ix;
    load_sp = sp;
    load_flags = fl;
    load_en = 1'b1;
    @(negedge sys_clk);
    load_en = 1'b0;
  endtask
  // Logs each bus cycle; start is left low so back-to-back runs stay legal
  task automatic run(input logic [15:0] pc, input int n);
    int k;
    k = 0;
    pc_in = pc;
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    `CHK("busy", 2'b10, {bus_active, ready})
    while (done !== 1'b1 && k < 60) begin
      k++;
      alog[k] = bus_addr;
      rlog[k] = bus_rw;
      wlog[k] = bus_wdata;
      @(negedge sys_clk);
    end
    `CHK("cycle count", n, k)
    `CHK("bus released", 3'b011, {bus_active, bus_rw, ready})
  endtask
  task automatic div(input logic [7:0] op, input logic [15:0] pair, ix, q, r,
                     input logic chk_r, input logic [2:0] zvc);
    MEM.poke(16'h0100, op);
    ld(pair, ix, 16'h0000, 8'hDF);
    run(16'h0100, 41);
    `CHK("quotient", q, first_index_reg)
    if (chk_r) `CHK("remainder", r, {upper_accumulator, lower_accumulator})
    `CHK("flags", {4'hD, 1'b1, zvc}, flag_register)
    `CHK("fetch addr", 32'h0100_0101, {alog[1], alog[2]})
    for (int i = 3; i <= 41; i++) `CHK("idle addr", 17'h1_FFFF, {rlog[i], alog[i]})
  endtask
  task automatic inc_mem(input logic [7:0] b0, b1, b2, input logic [15:0] ea,
                         input logic [7:0] m, input int n, input logic [7:0] fl, efl);
    MEM.poke(16'h0300, b0);
    MEM.poke(16'h0301, b1);
    MEM.poke(16'h0302, b2);
    MEM.poke(ea, m);
    ld(16'h0000, 16'h1000, 16'h0000, fl);
    run(16'h0300, n);
    `CHK("read addr", {ea, 16'hFFFF}, {alog[n-2], alog[n-1]})
    `CHK("write cycle", {1'b0, ea, m + 8'h01}, {rlog[n], alog[n], wlog[n]})
    `CHK("memory", m + 8'h01, MEM.mem[ea])
    `CHK("flags", efl, flag_register)
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_div;
    div(8'h03, 16'h4000, 16'h8000, 16'h8000, 16'h0000, 1'b1, 3'b000);
    div(8'h03, 16'h0000, 16'h0005, 16'h0000, 16'h0000, 1'b1, 3'b100);
    div(8'h03, 16'h8000, 16'h8000, 16'hFFFF, 16'h0000, 1'b0, 3'b010);
    div(8'h03, 16'h1234, 16'h0000, 16'hFFFF, 16'h0000, 1'b0, 3'b011);
    div(8'h02, 16'h1234, 16'h0010, 16'h0123, 16'h0004, 1'b1, 3'b000);
    div(8'h02, 16'h0003, 16'h0007, 16'h0000, 16'h0003, 1'b1, 3'b100);
    div(8'h02, 16'h1234, 16'h0000, 16'hFFFF, 16'h0000, 1'b0, 3'b001);
    div(8'h02, 16'hFFFF, 16'h0001, 16'hFFFF, 16'h0000, 1'b1, 3'b000);
    $display("divide test done");
  endtask
  task automatic t_inc;
    MEM.poke(16'h0200, 8'h4C);
    MEM.poke(16'h0201, 8'h5C);
    ld(16'h7FFF, 16'h1234, 16'h0000, 8'hD1);
    run(16'h0200, 2);
    `CHK("upper", 8'h80, upper_accumulator)
    `CHK("flags", 8'hDB, flag_register)
    run(16'h0201, 2);
    `CHK("pair", 16'h8000, {upper_accumulator, lower_accumulator})
    `CHK("flags", 8'hD5, flag_register)
    inc_mem(8'h7C, 8'h20, 8'h00, 16'h2000, 8'h41, 6, 8'hDE, 8'hD0);
    inc_mem(8'h6C, 8'h10, 8'h00, 16'h1010, 8'hFF, 6, 8'hD1, 8'hD5);
    inc_mem(8'h18, 8'h6C, 8'h05, 16'h3005, 8'h7F, 7, 8'hD0, 8'hDA);
    $display("increment test done");
  endtask
  task automatic t_sp_ix;
    MEM.poke(16'h0400, 8'h31);
    MEM.poke(16'h0401, 8'h08);
    MEM.poke(16'h0402, 8'h01);
    ld(16'h0000, 16'hFFFF, 16'h00FF, 8'hD9);
    run(16'h0400, 3);
    `CHK("stack read", 17'h1_00FF, {rlog[3], alog[3]})
    `CHK("stack", 16'h0100, stack_pointer)
    `CHK("flags", 8'hD9, flag_register)
    run(16'h0401, 3);
    `CHK("idle read", 17'h1_FFFF, {rlog[3], alog[3]})
    `CHK("index", 16'h0000, first_index_reg)
    `CHK("flags", 8'hDD, flag_register)
    run(16'h0402, 1);
    `CHK("unknown opcode", 1'b1, illegal)
    // Prefix followed by a byte this block does not own
    MEM.poke(16'h0403, 8'h18);
    MEM.poke(16'h0404, 8'h01);
    run(16'h0403, 2);
    `CHK("unknown prefixed opcode", 1'b1, illegal)
    `CHK("index kept", 16'h0000, first_index_reg)
    $display("stack and index test done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    resetn = 1'b0;
    start = 1'b0;
    load_en = 1'b0;
    pc_in = 16'h0000;
    index_y = 16'h3000;
    ld(16'h0000, 16'h0000, 16'h0000, 8'h00);
    repeat (11) @(negedge sys_clk);
    resetn = 1'b1;
    `CHK("reset flags", 8'hD0, flag_register)
    `CHK("reset bus", 17'h1_FFFF, {bus_rw, bus_addr})
    t_div;
    t_inc;
    t_sp_ix;
    final_report;
  end
  // Run needs under 600 cycles; a hang is cut off well past that
  initial begin
    repeat (3000) @(posedge sys_clk);
    errors++;
    final_report;
  end
endmodule
`default_nettype wire
